// ### verilog/dcc_regs.sv
// apb register bank and digital control for two analog comparators
// assumes raw comparator results arrive asynchronously from the analog side
// Functional notes
// (RULE1) filter code 0 bypasses; 1..7 need 1,2,4..64 stable clocks
// (RULE2) pin source bit picks unfiltered (0) or filtered (1) result
// (RULE3) edge polarity: both, rising, falling; code 3 gives no events
// (RULE4) positive input field drives the analog mux select
// (RULE5) negative input field picks pin, ladder, band-gap or dac
// (RULE6) invert bit inverts the result before later processing
// (RULE7) irq enable gates interrupt; with wake enable also gates wake-up
// (RULE8) comparator enable bit powers the comparator, resets off
// (RULE9) window output reads 1 when input lies inside the window
// (RULE10) status bits synchronised and forced 0 while disabled
// (RULE11) output bits synchronised and cleared while disabled
// (RULE12) wake flag set on wake event, cleared only by writing 1
// (RULE13) irq flag set on chosen edge, raises irq if enabled, w1c
// (RULE14) reference source bit picks analog supply or internal reference
// (RULE15) reference level field sets ladder tap of 1/6 plus level/24
// (RULE16) speed mode field drives comparator power and speed
// (RULE17) hysteresis field passed to analog circuit
// (RULE18) window compare bit derives result from both comparators
// (RULE19) window latch bit lets latch pin govern latched output
// (RULE20) latch follows result while pin high, holds while low
// (RULE21) window output is xor of the two status bits
// (RULE22) filter passes a new value only after it stays stable
// (RULE23) result goes through latch then filter before edge detection
// (RULE24) reserved bits read 0, writes ignored; writing 0 keeps flags
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module dcc_regs
   import dcc_pkg::*;
#(
   parameter int NCMP = 2
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [NCMP-1:0] comparator_raw_in,
   input wire logic [NCMP-1:0] latch_control_pin_in,
   output logic [NCMP-1:0] comparator_on_out,
   output logic [2*NCMP-1:0] positive_input_select_out,
   output logic [2*NCMP-1:0] negative_input_select_out,
   output logic [2*NCMP-1:0] hysteresis_select_out,
   output logic [2*NCMP-1:0] speed_mode_out,
   output logic [NCMP-1:0] comparator_output_pin_out,
   output logic ladder_enable_out,
   output logic reference_source_out,
   output logic [3:0] reference_level_out,
   output logic irq_out,
   output logic wake_out
);
   logic [31:0] ctl_r [NCMP];
   logic [31:0] vref_r;
   logic [NCMP-1:0] sync1_r;
   logic [NCMP-1:0] sync2_r;
   logic [NCMP-1:0] latch1_r;
   logic [NCMP-1:0] latch2_r;
   logic [NCMP-1:0] on_d1_r;
   logic [NCMP-1:0] on_d2_r;
   logic [NCMP-1:0] out_sts;
   logic [NCMP-1:0] cmp_sts;
   logic [NCMP-1:0] chan_in;
   logic [NCMP-1:0] filt;
   logic [NCMP-1:0] edge_ev;
   logic [NCMP-1:0] irq_flag_r;
   logic [NCMP-1:0] wake_flag_r;
   logic [NCMP-1:0] irq_en;
   logic [NCMP-1:0] wake_en;
   logic [NCMP-1:0] wr_clr;
   logic window_output;
   logic wr_acc;
   logic [3:0] ofs;
   logic [31:0] stat_rd;

   assign ofs = paddr_in[3:0];
   assign wr_acc = psel_in & penable_in & pwrite_in;
   // single-cycle access phase, no wait states
   assign pready_out = 1'b1;
   assign pslverr_out = 1'b0;

   // two-flop synchroniser from the analog domain
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= comparator_raw_in;
         sync2_r <= sync1_r;
      end
   end

   // latch pins come from outside the clock domain as well
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         latch1_r <= '0;
         latch2_r <= '0;
      end
      else
      begin
         latch1_r <= latch_control_pin_in;
         latch2_r <= latch1_r;
      end
   end

   // mask results until the synchroniser holds only post-enable samples,
   // otherwise stale samples of an unpowered comparator raise false edges
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         on_d1_r <= '0;
         on_d2_r <= '0;
      end
      else
      begin
         on_d1_r <= comparator_on_out;
         on_d2_r <= on_d1_r;
      end
   end

   // control registers, reserved bits masked on write
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         for (int i = 0; i < NCMP; i++)
            ctl_r[i] <= DCC_RST_VAL; // (RULE8)
         vref_r <= DCC_RST_VAL;
      end
      else if (wr_acc)
      begin
         for (int i = 0; i < NCMP; i++)
            if (ofs == DCC_OFS_CTL0 + 4'(4 * i))
               ctl_r[i] <= pwdata_in & DCC_CTL_MASK; // (RULE24)
         if (ofs == DCC_OFS_VREF)
            vref_r <= pwdata_in & DCC_VREF_MASK; // (RULE24)
      end
   end

   // window output is xor of the status bits
   assign window_output = cmp_sts[0] ^ cmp_sts[NCMP-1]; // (RULE21) (RULE9)

   genvar g;
   generate
      for (g = 0; g < NCMP; g++)
      begin : g_ch
         logic en;
         logic inv_res;
         assign en = ctl_r[g][DCC_B_EN];
         assign comparator_on_out[g] = en; // (RULE8)
         assign positive_input_select_out[2*g +: 2] = ctl_r[g][DCC_B_POS +: 2]; // (RULE4)
         assign negative_input_select_out[2*g +: 2] = ctl_r[g][DCC_B_NEG +: 2]; // (RULE5)
         assign hysteresis_select_out[2*g +: 2] = ctl_r[g][DCC_B_HYS +: 2]; // (RULE17)
         assign speed_mode_out[2*g +: 2] = ctl_r[g][DCC_B_MODE +: 2]; // (RULE16)
         assign inv_res = sync2_r[g] ^ ctl_r[g][DCC_B_INV]; // (RULE6)
         assign out_sts[g] = en & on_d2_r[g] & inv_res; // (RULE11)
         assign cmp_sts[g] = en & on_d2_r[g] & inv_res; // (RULE10)
         // window result replaces the channel's own result
         assign chan_in[g] = ctl_r[g][DCC_B_WCMP] ? window_output // (RULE18) (RULE23)
            : out_sts[g];
         assign irq_en[g] = ctl_r[g][DCC_B_IE];
         assign wake_en[g] = ctl_r[g][DCC_B_IE] & ctl_r[g][DCC_B_WAKE_ENABLE]; // (RULE7)
         assign wr_clr[g] = wr_acc & (ofs == DCC_OFS_STAT);

         dcc_chan u_chan (
            .clk_in(clk_in),
            .resetn_in(resetn_in),
            .enable_in(en),
            .result_in(chan_in[g]),
            .latch_en_in(ctl_r[g][DCC_B_WLAT]), // (RULE19)
            .latch_pin_in(latch2_r[g]),
            .filter_length_in(ctl_r[g][DCC_B_FILT +: 3]),
            .edge_polarity_in(ctl_r[g][DCC_B_POL +: 2]),
            .filtered_out(filt[g]),
            .edge_out(edge_ev[g])
         );

         // data output from a flop; source picks unfiltered or filtered
         always_ff @(posedge clk_in or negedge resetn_in)
         begin
            if (!resetn_in)
               comparator_output_pin_out[g] <= 1'b0;
            else
               comparator_output_pin_out[g] <= ctl_r[g][DCC_B_OSEL] ? filt[g] // (RULE2)
                  : out_sts[g];
         end

         // set wins over a same-cycle write-one clear
         always_ff @(posedge clk_in or negedge resetn_in)
         begin
            if (!resetn_in)
            begin
               irq_flag_r[g] <= 1'b0;
               wake_flag_r[g] <= 1'b0;
            end
            else
            begin
               if (edge_ev[g])
                  irq_flag_r[g] <= 1'b1; // (RULE13)
               else if (wr_clr[g] && pwdata_in[DCC_B_IF + g])
                  irq_flag_r[g] <= 1'b0; // (RULE13) (RULE24)
               if (edge_ev[g] && wake_en[g])
                  wake_flag_r[g] <= 1'b1; // (RULE12)
               else if (wr_clr[g] && pwdata_in[DCC_B_WKIF + g])
                  wake_flag_r[g] <= 1'b0; // (RULE12) (RULE24)
            end
         end
      end
   endgenerate

   assign irq_out = |(irq_flag_r & irq_en) | |(wake_flag_r & wake_en); // (RULE13) (RULE7)
   assign wake_out = |(wake_flag_r & wake_en); // (RULE7)

   // ladder powers only when some channel selects it
   always_comb
   begin
      ladder_enable_out = 1'b0;
      for (int i = 0; i < NCMP; i++)
         if (ctl_r[i][DCC_B_EN] && ctl_r[i][DCC_B_NEG +: 2] == 2'h1)
            ladder_enable_out = 1'b1;
   end
   assign reference_source_out = vref_r[DCC_B_RSRC]; // (RULE14)
   assign reference_level_out = vref_r[DCC_B_LVL +: 4]; // (RULE15)

   always_comb
   begin
      stat_rd = '0;
      stat_rd[DCC_B_IF +: NCMP] = irq_flag_r; // (RULE13)
      stat_rd[DCC_B_OUT +: NCMP] = out_sts; // (RULE11)
      stat_rd[DCC_B_WKIF +: NCMP] = wake_flag_r; // (RULE12)
      stat_rd[DCC_B_STS +: NCMP] = cmp_sts; // (RULE10)
      stat_rd[DCC_B_WO] = window_output; // (RULE9)
   end

   // registered read data; unmapped offsets read zero
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         prdata_out <= '0;
      else if (psel_in && !penable_in && !pwrite_in)
      begin
         case (ofs)
            DCC_OFS_CTL0: prdata_out <= ctl_r[0];
            DCC_OFS_CTL1: prdata_out <= ctl_r[NCMP-1];
            DCC_OFS_STAT: prdata_out <= stat_rd;
            DCC_OFS_VREF: prdata_out <= vref_r;
            default: prdata_out <= '0;
         endcase
      end
   end
endmodule

// ### verilog/dcc_pkg.sv
// package for the dual comparator control register bank
// assumes a 32-bit apb slave with word-aligned registers
package dcc_pkg;
   localparam logic [3:0] DCC_OFS_CTL0 = 4'h0;
   localparam logic [3:0] DCC_OFS_CTL1 = 4'h4;
   localparam logic [3:0] DCC_OFS_STAT = 4'h8;
   localparam logic [3:0] DCC_OFS_VREF = 4'hc;
   localparam logic [31:0] DCC_RST_VAL = 32'h0000_0000;
   localparam logic [31:0] DCC_CTL_MASK = 32'h3307_f3fb;
   localparam logic [31:0] DCC_VREF_MASK = 32'h0000_004f;
   // control field positions
   localparam int DCC_B_EN = 0;
   localparam int DCC_B_IE = 1;
   localparam int DCC_B_INV = 3;
   localparam int DCC_B_NEG = 4;
   localparam int DCC_B_POS = 6;
   localparam int DCC_B_POL = 8;
   localparam int DCC_B_OSEL = 12;
   localparam int DCC_B_FILT = 13;
   localparam int DCC_B_WAKE_ENABLE = 16;
   localparam int DCC_B_WLAT = 17;
   localparam int DCC_B_WCMP = 18;
   localparam int DCC_B_HYS = 24;
   localparam int DCC_B_MODE = 28;
   // status field positions
   localparam int DCC_B_IF = 0;
   localparam int DCC_B_OUT = 4;
   localparam int DCC_B_WKIF = 8;
   localparam int DCC_B_STS = 12;
   localparam int DCC_B_WO = 16;
   // ladder field positions
   localparam int DCC_B_LVL = 0;
   localparam int DCC_B_RSRC = 6;
   // edge polarity codes, then filter-off code and longest filter length
   localparam logic [1:0] DCC_POL_BOTH = 2'h0;
   localparam logic [1:0] DCC_POL_RISE = 2'h1;
   localparam logic [1:0] DCC_POL_FALL = 2'h2;
   localparam logic [2:0] DCC_FILT_OFF = 3'h0;
   localparam int DCC_FILT_MAX = 64;
endpackage

// ### verilog/dcc_chan.sv
// one comparator channel: latch, filter and edge detection
// assumes its input is already synchronised to clk_in
`timescale 1ns/100ps
module dcc_chan
   import dcc_pkg::*;
#(
   parameter int CNT_W = 7
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic enable_in,
   input wire logic result_in,
   input wire logic latch_en_in,
   input wire logic latch_pin_in,
   input wire logic [2:0] filter_length_in,
   input wire logic [1:0] edge_polarity_in,
   output logic filtered_out,
   output logic edge_out
);
   logic latched_r;
   logic latched_output;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] need;
   logic filt_r;
   logic filt_prev_r;
   logic filt_val;

   // pin high passes, pin low holds; a disabled channel shows 0 down to the pin
   assign latched_output = enable_in & ((latch_en_in & !latch_pin_in) ? latched_r : result_in); // (RULE20)

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         latched_r <= 1'b0;
      else
         latched_r <= latched_output;
   end

   // 1 shl (code-1) cycles of stability
   assign need = CNT_W'(1) << (filter_length_in - 3'h1); // (RULE1)

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         cnt_r <= '0;
         filt_r <= 1'b0;
      end
      else if (!enable_in)
      begin
         cnt_r <= '0;
         filt_r <= 1'b0;
      end
      else if (latched_output == filt_r)
         cnt_r <= '0;
      else if (cnt_r + CNT_W'(1) >= need)
      begin
         filt_r <= latched_output; // (RULE22)
         cnt_r <= '0;
      end
      else
         cnt_r <= cnt_r + CNT_W'(1);
   end

   assign filt_val = (filter_length_in == DCC_FILT_OFF) ? latched_output : filt_r; // (RULE1)
   assign filtered_out = filt_val; // (RULE23)

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         filt_prev_r <= 1'b0;
      else
         filt_prev_r <= filt_val;
   end

   always_comb
   begin
      case (edge_polarity_in) // (RULE3)
         DCC_POL_BOTH: edge_out = filt_val ^ filt_prev_r;
         DCC_POL_RISE: edge_out = filt_val & ~filt_prev_r;
         DCC_POL_FALL: edge_out = ~filt_val & filt_prev_r;
         default: edge_out = 1'b0;
      endcase
   end
endmodule

// ### tb/dcc_regs_properties.sv
// port checker for the comparator register bank
// assumes it is bound into every dcc_regs instance
`timescale 1ns/100ps
module dcc_regs_checker
   import dcc_pkg::*;
#(
   parameter int NCMP = 2
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [NCMP-1:0] comparator_on_out,
   input wire logic [2*NCMP-1:0] positive_input_select_out,
   input wire logic [2*NCMP-1:0] negative_input_select_out,
   input wire logic [2*NCMP-1:0] hysteresis_select_out,
   input wire logic [2*NCMP-1:0] speed_mode_out,
   input wire logic [NCMP-1:0] comparator_output_pin_out,
   input wire logic reference_source_out,
   input wire logic [3:0] reference_level_out,
   input wire logic irq_out,
   input wire logic wake_out
);
   logic [31:0] pw_r;
   logic [NCMP-1:0] ie_r;
   logic [NCMP-1:0] wk_r;
   logic wr_now;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   sequence s_wr(logic [3:0] ofs);
      wr_now && paddr_in[3:0] == ofs;
   endsequence
   assign wr_now = psel_in && penable_in && pwrite_in;
   always_ff @(posedge clk_in)
      pw_r <= pwdata_in;
   // shadow of the enables, since the bank does not show them at its ports
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ie_r <= '0;
         wk_r <= '0;
      end
      else if (wr_now && paddr_in[3] == 1'b0 && paddr_in[1:0] == 2'h0)
      begin
         ie_r[paddr_in[2]] <= pwdata_in[DCC_B_IE];
         wk_r[paddr_in[2]] <= pwdata_in[DCC_B_WAKE_ENABLE];
      end
   end
   a_enable_write: assert property (s_wr(DCC_OFS_CTL0)
      |=> comparator_on_out[0] == pw_r[0])
      else $error("enable output mismatch");
   a_posin_write: assert property (s_wr(DCC_OFS_CTL0)
      |=> positive_input_select_out[1:0] == pw_r[7:6])
      else $error("positive select mismatch");
   a_negin_write: assert property (s_wr(DCC_OFS_CTL1)
      |=> negative_input_select_out[3:2] == pw_r[5:4])
      else $error("negative select mismatch");
   a_hyst_write: assert property (s_wr(DCC_OFS_CTL0)
      |=> hysteresis_select_out[1:0] == pw_r[25:24])
      else $error("hysteresis mismatch");
   a_speed_write: assert property (s_wr(DCC_OFS_CTL1)
      |=> speed_mode_out[3:2] == pw_r[29:28])
      else $error("speed mode mismatch");
   a_ladder_write: assert property (s_wr(DCC_OFS_VREF)
      |=> reference_level_out == pw_r[3:0] && reference_source_out == pw_r[6])
      else $error("ladder setting mismatch");
   a_off_pin_low: assert property ((!comparator_on_out[0]) [*3] |-> !comparator_output_pin_out[0])
      else $error("disabled comparator drives pin");
   a_irq_gated: assert property (irq_out |-> |ie_r)
      else $error("interrupt without enable");
   a_wake_gated: assert property (wake_out |-> |(ie_r & wk_r))
      else $error("wake without enables");
   a_misaligned_ignored: assert property (wr_now && paddr_in[1:0] != 2'h0
      |=> $stable(comparator_on_out) && $stable(reference_level_out))
      else $error("unmapped write changed state");
endmodule
bind dcc_regs dcc_regs_checker #(.NCMP(NCMP)) i_chk (.*);

// ### tb/dcc_analog_model.sv
// behavioural pair of analog comparators behind the bank
// assumes level_in changes only just after rising clock edges
`timescale 1ns/100ps
module dcc_analog_model
(
   input wire logic clk_in,
   input wire logic [1:0] comparator_on_in,
   input wire logic [1:0] level_in,
   output logic [1:0] raw_out
);
   logic [1:0] junk_r = 2'h1;
   // an unpowered comparator has no valid level, so show a moving pattern
   always @(posedge clk_in)
      junk_r <= ~junk_r;
   assign raw_out = (level_in & comparator_on_in) | (junk_r & ~comparator_on_in);
endmodule

// ### tb/testbench.sv
// self-checking bench for the comparator register bank
// assumes apb slave always ready; analog side from the behavioural model
`timescale 1ns/100ps
module testbench
   import dcc_pkg::*;
;
   logic clk_in, resetn_in, psel_in, penable_in, pwrite_in;
   logic [31:0] paddr_in, pwdata_in, prdata_out, q;
   logic pready_out, pslverr_out, irq_out, wake_out, rsrc, lad;
   logic [1:0] lvl, raw, latch, on, pin;
   logic [3:0] pos, neg, hys, mode, rlvl;
   int failures = 0;
   int n_compared = 0;
   dcc_regs i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .comparator_raw_in(raw), .latch_control_pin_in(latch),
      .comparator_on_out(on), .positive_input_select_out(pos),
      .negative_input_select_out(neg), .hysteresis_select_out(hys), .speed_mode_out(mode),
      .comparator_output_pin_out(pin), .ladder_enable_out(lad), .reference_source_out(rsrc),
      .reference_level_out(rlvl), .irq_out(irq_out), .wake_out(wake_out));
   dcc_analog_model i_ana (.clk_in(clk_in), .comparator_on_in(on), .level_in(lvl),
      .raw_out(raw));
   always #2 clk_in = ~clk_in;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1)
         @(posedge clk_in);
      q = prdata_out;
      chk(pslverr_out, 1'b0);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      // return once the write has settled, so callers see its effect
      @(posedge clk_in);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [31:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic t_regs;
      for (int i = 0; i < 16; i += 4)
      begin
         rd(i);
         chk(q, DCC_RST_VAL);
      end
      wr(DCC_OFS_CTL0, '1);
      wr(32'h1, 32'h0);
      rd(DCC_OFS_CTL0);
      chk(q, DCC_CTL_MASK);
      wr(DCC_OFS_VREF, '1);
      rd(DCC_OFS_VREF);
      chk(q, DCC_VREF_MASK);
      chk({rsrc, rlvl}, 32'h1f);
      for (int k = 0; k < 4; k++)
      begin
         wr(DCC_OFS_CTL1, k << 4 | k << 6 | k << 24 | k << 28 | 1);
         chk(lad, k == 1);
         chk({pos[3:2], neg[3:2], hys[3:2], mode[3:2]}, {4{k[1:0]}});
      end
      wr(DCC_OFS_CTL0, 32'h0);
      wr(DCC_OFS_STAT, '1);
      $display("register test done");
   endtask
   task automatic t_status;
      lvl <= 2'b01;
      wr(DCC_OFS_CTL0, 32'h1);
      wr(DCC_OFS_CTL1, 32'h1);
      rd(DCC_OFS_STAT);
      chk(q & 32'h1_3030, 32'h1_1010);
      wr(DCC_OFS_CTL0, 32'h9);
      rd(DCC_OFS_STAT);
      chk(q & 32'h1_3030, 32'h0);
      wr(DCC_OFS_CTL0, 32'h0);
      lvl <= 2'b11;
      repeat (4) @(posedge clk_in);
      rd(DCC_OFS_STAT);
      chk(q & 32'h1_3030, 32'h1_2020);
      wr(DCC_OFS_CTL1, 32'h0);
      wr(DCC_OFS_STAT, '1);
      $display("status test done");
   endtask
   task automatic t_events;
      for (int p = 0; p < 4; p++)
      begin
         lvl <= 2'b00;
         wr(DCC_OFS_CTL0, 32'h1_0003 | p << 8);
         lvl <= 2'b01;
         repeat (6) @(posedge clk_in);
         rd(DCC_OFS_STAT);
         chk({q[8], q[0], irq_out, wake_out}, {4{p < 2}});
         wr(DCC_OFS_STAT, 32'h0);
         chk(irq_out, p < 2);
         wr(DCC_OFS_STAT, 32'h101);
         rd(DCC_OFS_STAT);
         chk(q & 32'h303, 32'h0);
         lvl <= 2'b00;
         repeat (6) @(posedge clk_in);
         chk({irq_out, wake_out}, {2{p == 0 || p == 2}});
         wr(DCC_OFS_STAT, 32'h303);
      end
      $display("event test done");
   endtask
   task automatic t_filter;
      int n;
      logic seen;
      for (int c = 1; c < 8; c += 3)
      begin
         n = 1 << (c - 1);
         wr(DCC_OFS_CTL0, 32'h1001 | c << 13);
         seen = 1'b0;
         if (n > 1)
         begin
            lvl <= 2'b01;
            repeat (n - 1) @(posedge clk_in);
            lvl <= 2'b00;
            repeat (n + 6)
            begin
               @(posedge clk_in);
               seen |= pin[0];
            end
            chk(seen, 1'b0);
         end
         lvl <= 2'b01;
         repeat (n) @(posedge clk_in);
         chk(pin[0], 1'b0);
         repeat (8) @(posedge clk_in);
         chk(pin[0], 1'b1);
         lvl <= 2'b00;
         wr(DCC_OFS_CTL0, 32'h0);
      end
      // unfiltered pin path must not wait for the long filter
      wr(DCC_OFS_CTL0, 32'he001);
      lvl <= 2'b01;
      repeat (5) @(posedge clk_in);
      chk(pin[0], 1'b1);
      lvl <= 2'b00;
      wr(DCC_OFS_CTL0, 32'h0);
      $display("filter test done");
   endtask
   task automatic t_window;
      wr(DCC_OFS_CTL0, 32'h2_1001);
      lvl <= 2'b01;
      repeat (8) @(posedge clk_in);
      chk(pin[0], 1'b0);
      latch <= 2'b01;
      repeat (5) @(posedge clk_in);
      chk(pin[0], 1'b1);
      latch <= 2'b00;
      lvl <= 2'b00;
      repeat (8) @(posedge clk_in);
      chk(pin[0], 1'b1);
      wr(DCC_OFS_CTL0, 32'h4_1001);
      wr(DCC_OFS_CTL1, 32'h1);
      lvl <= 2'b01;
      repeat (6) @(posedge clk_in);
      chk(pin[0], 1'b1);
      lvl <= 2'b11;
      repeat (6) @(posedge clk_in);
      chk(pin[0], 1'b0);
      $display("window test done");
   endtask
   task automatic give_verdict;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      clk_in = 1'b0;
      resetn_in = 1'b0;
      {psel_in, penable_in, pwrite_in} = 3'h0;
      paddr_in = 32'h0;
      pwdata_in = 32'h0;
      lvl = 2'h0;
      latch = 2'h0;
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      t_regs;
      t_status;
      t_events;
      t_filter;
      t_window;
      give_verdict;
   end
   // generous bound: the whole sequence needs well under a tenth of it
   initial
   begin
      #100000;
      failures++;
      give_verdict;
   end
endmodule
